/* src/pmic_protected_register_bank.v */
/*
  configuration register bank with key-protected upper map, behind a byte port.
  assumes: the serial bus framing lives outside and presents one-cycle strobes
  for offset, written byte, read request and end of transaction.
*/
`timescale 1ns/1ps
`include "pmic_regs_consts.vh"

module pmic_protected_register_bank #(
  parameter HOLD_CYCLES = `BUTTON_HOLD_CYCLES,
  parameter [7:0] CHIP_IDENTITY_VAL = 8'h00,
  parameter [7:0] RST_BUCK1_VAL = 8'h00,
  parameter [7:0] RST_BUCK2_VAL = 8'h00,
  parameter [7:0] RST_LOAD_SW1_VAL = 8'h00,
  parameter [7:0] RST_LOAD_SW2_VAL = 8'h00,
  parameter [7:0] RST_SEQ_STROBE_1_VAL = 8'h00,
  parameter [7:0] RST_SEQ_STROBE_2_VAL = 8'h00,
  parameter [7:0] RST_SEQ_STROBE_3_VAL = 8'h00,
  parameter [7:0] RST_SEQ_DELAY_1_VAL = 8'h00
) (
  input wire ref_clk,
  input wire rst_n,
  input wire ce,
  input wire sub_addr_we,
  input wire [`ADDR_W-1:0] sub_addr,
  input wire wr_we,
  input wire [`DATA_W-1:0] wr_data,
  input wire rd_req,
  input wire txn_end,
  input wire hw_reset_pin_n,
  input wire push_button_input,
  input wire fault,
  input wire leave_active,
  input wire [`DATA_W-1:0] int_flags_in,
  input wire [`DATA_W-1:0] status_in,
  input wire [`DATA_W-1:0] power_good_in,
  output reg [`DATA_W-1:0] rd_data_q,
  output reg rd_valid_q,
  output reg [`NUM_REGS*`DATA_W-1:0] reg_image_q,
  output reg [`ADDR_W-1:0] ptr_q,
  output reg key_live_q,
  output reg stage_valid_q
);

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  reg rst_meta_q;
  reg rst_sync_q;

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // ----------------------------------------
  // per-offset tables
  // ----------------------------------------
  function [`DATA_W-1:0] reset_value;
    input [`ADDR_W-1:0] a;
    begin
      case (a)
        `OFS_POWER_PATH: reset_value = `RST_POWER_PATH;
        `OFS_INT_FLAGS_MASKS: reset_value = `RST_INT_FLAGS_MASKS;
        `OFS_CHARGER_CTRL_1: reset_value = `RST_CHARGER_CTRL_1;
        `OFS_CHARGER_CTRL_2: reset_value = `RST_CHARGER_CTRL_2;
        `OFS_CHARGER_CTRL_3: reset_value = `RST_CHARGER_CTRL_3;
        `OFS_BACKLIGHT_CTRL: reset_value = `RST_BACKLIGHT_CTRL;
        `OFS_POWER_GOOD_DELAY: reset_value = `RST_POWER_GOOD_DELAY;
        `OFS_BUCK1: reset_value = RST_BUCK1_VAL;
        `OFS_BUCK2: reset_value = RST_BUCK2_VAL;
        `OFS_BUCK3: reset_value = `RST_BUCK3;
        `OFS_BUCK_SLEW: reset_value = `RST_BUCK_SLEW;
        `OFS_LIN_REG1: reset_value = `RST_LIN_REG1;
        `OFS_LIN_REG2: reset_value = `RST_LIN_REG2;
        `OFS_LOAD_SW1: reset_value = RST_LOAD_SW1_VAL;
        `OFS_LOAD_SW2: reset_value = RST_LOAD_SW2_VAL;
        `OFS_UNDERVOLTAGE: reset_value = `RST_UNDERVOLTAGE;
        `OFS_SEQ_STROBE_1: reset_value = RST_SEQ_STROBE_1_VAL;
        `OFS_SEQ_STROBE_2: reset_value = RST_SEQ_STROBE_2_VAL;
        `OFS_SEQ_STROBE_3: reset_value = RST_SEQ_STROBE_3_VAL;
        `OFS_SEQ_STROBE_4: reset_value = `RST_SEQ_STROBE_4;
        `OFS_SEQ_DELAY_1: reset_value = RST_SEQ_DELAY_1_VAL;
        default: reset_value = `RST_ZERO;
      endcase
    end
  endfunction

  // bits software may change; the rest come from outside or read zero
  function [`DATA_W-1:0] write_mask;
    input [`ADDR_W-1:0] a;
    begin
      case (a)
        `OFS_CHIP_IDENTITY: write_mask = `WMASK_NONE;
        `OFS_INT_FLAGS_MASKS: write_mask = `WMASK_INT;
        `OFS_DEVICE_STATUS: write_mask = `WMASK_STATUS;
        `OFS_POWER_GOOD_FLAGS: write_mask = `WMASK_NONE;
        `OFS_GAP: write_mask = `WMASK_NONE;
        `OFS_LAST_PROTECTED: write_mask = `WMASK_NONE;
        default: write_mask = (a < `NUM_REGS) ? `WMASK_ALL : `WMASK_NONE;
      endcase
    end
  endfunction

  function [`DATA_W-1:0] hw_bits;
    input [`ADDR_W-1:0] a;
    input [`DATA_W-1:0] int_f;
    input [`DATA_W-1:0] stat;
    input [`DATA_W-1:0] pg;
    begin
      case (a)
        `OFS_CHIP_IDENTITY: hw_bits = CHIP_IDENTITY_VAL;
        `OFS_INT_FLAGS_MASKS: hw_bits = int_f & ~`WMASK_INT;
        `OFS_DEVICE_STATUS: hw_bits = stat & ~`WMASK_STATUS;
        `OFS_POWER_GOOD_FLAGS: hw_bits = pg;
        default: hw_bits = `RST_ZERO;
      endcase
    end
  endfunction

  // what a read or the image shows for one offset, key included
  function [`DATA_W-1:0] visible_byte;
    input [`ADDR_W-1:0] a;
    input [`DATA_W-1:0] m;
    input [`DATA_W-1:0] k;
    begin
      if (a == `OFS_WRITE_KEY) begin
        visible_byte = k;
      end else begin
        visible_byte = (m & write_mask(a)) |
                       hw_bits(a, int_flags_in, status_in, power_good_in);
      end
    end
  endfunction

  // ----------------------------------------
  // default-restore events
  // ----------------------------------------
  reg init_done_q;
  wire button_expired;
  wire pin_held_low;
  wire power_on_fill;
  wire restore_defaults;

  button_hold_timer #(
    .HOLD_CYCLES(HOLD_CYCLES)
  ) u_button_hold (
    .ref_clk(ref_clk),
    .rst_n(rst_sync_q),
    .ce(ce),
    .push_button_input(push_button_input),
    .hold_expired_q(button_expired)
  );

  assign pin_held_low = ~hw_reset_pin_n;
  // array leaves power-on at zero, so the first enabled edge fills it
  assign power_on_fill = ~init_done_q;
  assign restore_defaults = leave_active | button_expired | pin_held_low | fault |
                            power_on_fill;

  // ----------------------------------------
  // protection check on the addressed offset
  // ----------------------------------------
  reg [`DATA_W-1:0] key_q;
  wire [1:0] prot_level;
  wire key_ok;

  write_guard u_guard (
    .addr(ptr_q),
    .key(key_q),
    .prot_level(prot_level),
    .key_ok(key_ok)
  );

  reg [`DATA_W-1:0] stage_data_q;
  reg [`ADDR_W-1:0] stage_addr_q;
  reg [`STAGE_AGE_W-1:0] stage_age_q;
  reg key_wr_this_txn_q;
  reg [`DATA_W-1:0] mem_q [0:`NUM_REGS-1];

  wire is_key_wr;
  wire in_map;
  wire second_ok;
  wire do_store;
  wire do_stage;
  wire [`IDX_W-1:0] idx;
  wire [`DATA_W-1:0] wmask;

  assign idx = ptr_q[`IDX_W-1:0];
  assign in_map = (ptr_q < `NUM_REGS);
  assign wmask = write_mask(ptr_q);
  assign is_key_wr = wr_we & (ptr_q == `OFS_WRITE_KEY);
  assign second_ok = stage_valid_q & (stage_age_q == `STAGE_AGE_SECOND) &
                     (stage_addr_q == ptr_q) & (stage_data_q == wr_data);
  assign do_store = wr_we & in_map & ~is_key_wr &
                    ((prot_level == `PROT_NONE) |
                     ((prot_level == `PROT_SINGLE) & key_ok) |
                     ((prot_level == `PROT_DOUBLE) & key_ok & second_ok));
  assign do_stage = wr_we & (prot_level == `PROT_DOUBLE) & key_ok & ~second_ok;

  // ----------------------------------------
  // register array and key register
  // ----------------------------------------
  integer i;

  always @(posedge ref_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      for (i = 0; i < `NUM_REGS; i = i + 1) begin
        mem_q[i] <= `RST_ZERO;
      end
      key_q <= `RST_ZERO;
    end else if (ce) begin
      if (restore_defaults) begin
        for (i = 0; i < `NUM_REGS; i = i + 1) begin
          mem_q[i] <= reset_value(i[`ADDR_W-1:0]);
        end
        key_q <= `RST_ZERO;
      end else begin
        if (is_key_wr) begin
          key_q <= wr_data;
        end else if (txn_end & key_live_q & ~key_wr_this_txn_q) begin
          key_q <= `RST_ZERO;
        end
        if (do_store) begin
          mem_q[idx] <= (mem_q[idx] & ~wmask) | (wr_data & wmask);
        end
      end
    end
  end

  // image shows defaults until the array has been filled

  always @(posedge ref_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      init_done_q <= 1'b0;
    end else if (ce) begin
      init_done_q <= 1'b1;
    end
  end

  // ----------------------------------------
  // key lifetime over transactions
  // ----------------------------------------
  always @(posedge ref_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      key_live_q <= 1'b0;
      key_wr_this_txn_q <= 1'b0;
    end else if (ce) begin
      if (restore_defaults) begin
        key_live_q <= 1'b0;
        key_wr_this_txn_q <= 1'b0;
      end else if (txn_end) begin
        key_live_q <= key_wr_this_txn_q | is_key_wr;
        key_wr_this_txn_q <= 1'b0;
      end else if (is_key_wr) begin
        key_wr_this_txn_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // staged first write of a double sequence
  // ----------------------------------------
  always @(posedge ref_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      stage_valid_q <= 1'b0;
      stage_addr_q <= `RST_ZERO;
      stage_data_q <= `RST_ZERO;
      stage_age_q <= {`STAGE_AGE_W{1'b0}};
    end else if (ce) begin
      if (restore_defaults) begin
        stage_valid_q <= 1'b0;
        stage_age_q <= {`STAGE_AGE_W{1'b0}};
      end else if (do_stage) begin
        stage_valid_q <= 1'b1;
        stage_addr_q <= ptr_q;
        stage_data_q <= wr_data;
        stage_age_q <= {`STAGE_AGE_W{1'b0}};
      end else if (do_store & (prot_level == `PROT_DOUBLE)) begin
        stage_valid_q <= 1'b0;
      end else if (txn_end & stage_valid_q) begin
        if (stage_age_q == `STAGE_AGE_SECOND) begin
          stage_valid_q <= 1'b0;
        end else if (stage_age_q == `STAGE_AGE_KEY &&
                     !(key_wr_this_txn_q | is_key_wr)) begin
          stage_valid_q <= 1'b0;
        end else begin
          stage_age_q <= stage_age_q + 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // offset pointer and read path
  // ----------------------------------------
  always @(posedge ref_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      ptr_q <= `RST_ZERO;
      rd_data_q <= `RST_ZERO;
      rd_valid_q <= 1'b0;
    end else if (ce) begin
      rd_valid_q <= rd_req;
      if (sub_addr_we) begin
        ptr_q <= sub_addr;
      end else if (wr_we | rd_req) begin
        ptr_q <= ptr_q + 1'b1;
      end
      if (rd_req) begin
        rd_data_q <= visible_byte(ptr_q, mem_q[idx], key_q);
      end
    end
  end

  // ----------------------------------------
  // register image towards the power logic
  // ----------------------------------------
  integer j;

  always @(posedge ref_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      reg_image_q <= {`NUM_REGS*`DATA_W{1'b0}};
    end else if (ce) begin
      for (j = 0; j < `NUM_REGS; j = j + 1) begin
        reg_image_q[j*`DATA_W +: `DATA_W] <= init_done_q ?
          visible_byte(j[`ADDR_W-1:0], mem_q[j], key_q) : reset_value(j[`ADDR_W-1:0]);
      end
    end
  end

endmodule

/* inc/pmic_regs_consts.vh */
/*
  offsets, field masks, reset values and timing for the protected register bank.
  assumes: included by the design files below src/, no processes here.
*/
// Summary of operation
// - writes to 0x0d..0x1f need valid key first
// - key clears after the following transaction ends
// - reads of protected registers always succeed
// - single-protected write stores only if key matches
// - first double-protected write only staged
// - second matching unlocked write commits staged byte
// - intervening transaction abandons double write
// - leaving active state restores all defaults
// - power-on reset restores all defaults
// - button held over 8 s restores defaults
// - reset pin low or fault restores defaults
// - read-only reserved bits ignore writes
// - protection levels per offset range
// - byte port with auto-incrementing offset
`ifndef PMIC_REGS_CONSTS_VH
`define PMIC_REGS_CONSTS_VH

`define ADDR_W 8
`define DATA_W 8
`define NUM_REGS 32
`define IDX_W 5

`define OFS_CHIP_IDENTITY 8'h00
`define OFS_POWER_PATH 8'h01
`define OFS_INT_FLAGS_MASKS 8'h02
`define OFS_CHARGER_CTRL_0 8'h03
`define OFS_CHARGER_CTRL_1 8'h04
`define OFS_CHARGER_CTRL_2 8'h05
`define OFS_CHARGER_CTRL_3 8'h06
`define OFS_BACKLIGHT_CTRL 8'h07
`define OFS_BACKLIGHT_DUTY 8'h08
`define OFS_ANALOG_MUX 8'h09
`define OFS_DEVICE_STATUS 8'h0a
`define OFS_WRITE_KEY 8'h0b
`define OFS_POWER_GOOD_FLAGS 8'h0c
`define OFS_POWER_GOOD_DELAY 8'h0d
`define OFS_BUCK1 8'h0e
`define OFS_BUCK2 8'h0f
`define OFS_BUCK3 8'h10
`define OFS_BUCK_SLEW 8'h11
`define OFS_LIN_REG1 8'h12
`define OFS_LIN_REG2 8'h13
`define OFS_LOAD_SW1 8'h14
`define OFS_LOAD_SW2 8'h15
`define OFS_RAIL_ENABLES 8'h16
`define OFS_GAP 8'h17
`define OFS_UNDERVOLTAGE 8'h18
`define OFS_SEQ_STROBE_1 8'h19
`define OFS_SEQ_STROBE_2 8'h1a
`define OFS_SEQ_STROBE_3 8'h1b
`define OFS_SEQ_STROBE_4 8'h1c
`define OFS_SEQ_DELAY_1 8'h1d
`define OFS_SEQ_DELAY_2 8'h1e
`define OFS_LAST_PROTECTED 8'h1f

`define RST_POWER_PATH 8'h3d
`define RST_INT_FLAGS_MASKS 8'h80
`define RST_CHARGER_CTRL_1 8'hb1
`define RST_CHARGER_CTRL_2 8'h80
`define RST_CHARGER_CTRL_3 8'hb2
`define RST_BACKLIGHT_CTRL 8'hb1
`define RST_POWER_GOOD_DELAY 8'h0c
`define RST_BUCK3 8'h08
`define RST_BUCK_SLEW 8'h06
`define RST_LIN_REG1 8'h09
`define RST_LIN_REG2 8'h38
`define RST_UNDERVOLTAGE 8'h03
`define RST_SEQ_STROBE_4 8'h40
`define RST_ZERO 8'h00

`define WMASK_ALL 8'hff
`define WMASK_NONE 8'h00
`define WMASK_INT 8'hf0
`define WMASK_STATUS 8'h80

`define UNLOCK_KEY 8'h7d

`define PROT_NONE 2'h0
`define PROT_SINGLE 2'h1
`define PROT_DOUBLE 2'h2

`define STAGE_AGE_W 2
`define STAGE_AGE_KEY 2'h1
`define STAGE_AGE_SECOND 2'h2

`define CLK_FREQ_KHZ 100000
`define BUTTON_HOLD_MS 8000
`define BUTTON_HOLD_CYCLES (`BUTTON_HOLD_MS * `CLK_FREQ_KHZ)
`define HOLD_CNT_W 30

`endif

/* src/write_guard.v */
/*
  classifies an offset into its protection level and checks the unlock key.
  assumes: purely combinational, fed from the register bank.
*/
`timescale 1ns/1ps
`include "pmic_regs_consts.vh"

module write_guard (
  input wire [`ADDR_W-1:0] addr,
  input wire [`DATA_W-1:0] key,
  output reg [1:0] prot_level,
  output wire key_ok
);

  // ----------------------------------------
  // level per offset range
  // ----------------------------------------
  always @* begin
    if (addr >= `OFS_BUCK1 && addr <= `OFS_LOAD_SW2) begin
      prot_level = `PROT_DOUBLE;
    end else if (addr == `OFS_POWER_GOOD_DELAY || addr == `OFS_RAIL_ENABLES ||
                 (addr >= `OFS_UNDERVOLTAGE && addr <= `OFS_SEQ_DELAY_2)) begin
      prot_level = `PROT_SINGLE;
    end else begin
      prot_level = `PROT_NONE;
    end
  end

  assign key_ok = ((key ^ addr) == `UNLOCK_KEY);

endmodule

/* src/button_hold_timer.v */
/*
  measures how long the push button is held low, pulses once per hold period.
  assumes: button input synchronous to ref_clk, synchronous reset copy given.
*/
`timescale 1ns/1ps
`include "pmic_regs_consts.vh"

module button_hold_timer #(
  parameter HOLD_CYCLES = `BUTTON_HOLD_CYCLES
) (
  input wire ref_clk,
  input wire rst_n,
  input wire ce,
  input wire push_button_input,
  output reg hold_expired_q
);

  reg [`HOLD_CNT_W-1:0] hold_cnt_q;

  // ----------------------------------------
  // hold counter, re-arms every period while held
  // ----------------------------------------
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_cnt_q <= {`HOLD_CNT_W{1'b0}};
      hold_expired_q <= 1'b0;
    end else if (ce) begin
      hold_expired_q <= 1'b0;
      if (push_button_input) begin
        hold_cnt_q <= {`HOLD_CNT_W{1'b0}};
      end else if (hold_cnt_q == HOLD_CYCLES[`HOLD_CNT_W-1:0]) begin
        hold_cnt_q <= {`HOLD_CNT_W{1'b0}};
        hold_expired_q <= 1'b1;
      end else begin
        hold_cnt_q <= hold_cnt_q + 1'b1;
      end
    end
  end

endmodule

/* sim/pmic_bank_checker_assertions.sv */
/*
  port-level checks for the protected register bank.
  assumes: bound to the bank, one clock ref_clk, rst_n as its reset.
*/
`timescale 1ns/1ps
`include "pmic_regs_consts.vh"

module pmic_bank_checker (
  input wire ref_clk,
  input wire rst_n,
  input wire ce,
  input wire sub_addr_we,
  input wire [`ADDR_W-1:0] sub_addr,
  input wire wr_we,
  input wire [`DATA_W-1:0] wr_data,
  input wire rd_req,
  input wire txn_end,
  input wire hw_reset_pin_n,
  input wire fault,
  input wire leave_active,
  input wire rd_valid_q,
  input wire [`NUM_REGS*`DATA_W-1:0] reg_image_q,
  input wire [`ADDR_W-1:0] ptr_q,
  input wire key_live_q,
  input wire stage_valid_q
);
  // ----------------
  // helper logic
  // ----------------
  reg key_wr_q;
  wire restore = !hw_reset_pin_n || fault || leave_active;
  wire [7:0] key_byte = reg_image_q[95:88];
  wire [7:0] enab_byte = reg_image_q[183:176];
  wire [7:0] buck1_byte = reg_image_q[119:112];
  wire key_hit = key_live_q && ((key_byte ^ ptr_q) == `UNLOCK_KEY);

  // key rewritten inside the current transaction
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      key_wr_q <= 1'b0;
    end else if (ce) begin
      key_wr_q <= !txn_end && (key_wr_q || (wr_we && ptr_q == `OFS_WRITE_KEY));
    end
  end

  // ----------------
  // properties
  // ----------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence settle_s;
    ce [*2];
  endsequence
  sequence wr_at_s(logic [7:0] ofs);
    wr_we && ce && !restore && ptr_q == ofs;
  endsequence

  rd_answer_a: assert property (rd_req && ce |=> rd_valid_q)
    else $error("read strobe gave no valid pulse");
  rd_cause_a: assert property (rd_valid_q && $past(ce) |-> $past(rd_req))
    else $error("valid pulse without read strobe");
  ptr_step_a: assert property ((wr_we || rd_req) && ce && !sub_addr_we && !restore
    |=> ptr_q == $past(ptr_q) + 8'h01) else $error("pointer did not advance");
  ptr_load_a: assert property (sub_addr_we && ce && !(wr_we || rd_req || restore)
    |=> ptr_q == $past(sub_addr)) else $error("pointer not loaded");
  key_drop_a: assert property (key_live_q && txn_end && ce && !key_wr_q
    |=> !key_live_q) else $error("key outlived the following transaction");
  key_rise_a: assert property ($rose(key_live_q) |-> $past(txn_end) && $past(key_wr_q))
    else $error("key went live outside a key transaction");
  restore_clr_a: assert property (restore && ce |=> !key_live_q && !stage_valid_q)
    else $error("restore left key or staged byte");
  restore_dflt_a: assert property (restore && ce ##1 settle_s |=> key_byte == 8'h00
    && reg_image_q[15:8] == `RST_POWER_PATH && reg_image_q[135:128] == `RST_BUCK3)
    else $error("restore did not bring defaults");
  enab_take_a: assert property (wr_at_s(`OFS_RAIL_ENABLES) ##0 key_hit ##1 settle_s
    |=> enab_byte == $past(wr_data, 3)) else $error("unlocked write not stored");
  enab_keep_a: assert property (wr_at_s(`OFS_RAIL_ENABLES) ##0 !key_hit ##1 settle_s
    |=> enab_byte == $past(enab_byte, 3)) else $error("locked write changed register");
  stage_hold_a: assert property (wr_at_s(`OFS_BUCK1) ##0 key_hit && !stage_valid_q
    ##1 settle_s |=> stage_valid_q && buck1_byte == $past(buck1_byte, 3))
    else $error("first double write not only staged");
endmodule

bind pmic_protected_register_bank pmic_bank_checker i_pmic_bank_checker (
  .ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .sub_addr_we(sub_addr_we), .sub_addr(sub_addr),
  .wr_we(wr_we), .wr_data(wr_data), .rd_req(rd_req), .txn_end(txn_end),
  .hw_reset_pin_n(hw_reset_pin_n), .fault(fault), .leave_active(leave_active),
  .rd_valid_q(rd_valid_q), .reg_image_q(reg_image_q), .ptr_q(ptr_q),
  .key_live_q(key_live_q), .stage_valid_q(stage_valid_q)
);

/* sim/host_ctrl_model.sv */
/*
  host side of the byte port: offset, write, read and stop strobes.
  assumes: ref_clk shared with the bank, tasks called from the bench.
*/
`timescale 1ns/1ps
`include "pmic_regs_consts.vh"

module host_ctrl_model (
  input wire ref_clk,
  input wire [7:0] rd_data_q,
  input wire rd_valid_q,
  output reg sub_addr_we = 1'b0,
  output reg [7:0] sub_addr = 8'h00,
  output reg wr_we = 1'b0,
  output reg [7:0] wr_data = 8'h00,
  output reg rd_req = 1'b0,
  output reg txn_end = 1'b0
);
  reg [7:0] rd_seen = 8'h00;
  reg rd_ok = 1'b0;

  // ----------------
  // single strobes
  // ----------------
  task edge1;
    begin
      @(posedge ref_clk);
      #1;
    end
  endtask
  // released buses show the inverse, never a stale copy
  task put_addr(input [7:0] a);
    begin
      edge1;
      sub_addr_we = 1'b1;
      sub_addr = a;
      edge1;
      sub_addr_we = 1'b0;
      sub_addr = ~a;
    end
  endtask
  task put_byte(input [7:0] d);
    begin
      edge1;
      wr_we = 1'b1;
      wr_data = d;
      edge1;
      wr_we = 1'b0;
      wr_data = ~d;
    end
  endtask
  task get_byte;
    begin
      edge1;
      rd_req = 1'b1;
      edge1;
      rd_req = 1'b0;
      rd_ok = rd_valid_q;
      rd_seen = rd_data_q;
    end
  endtask
  task end_txn;
    begin
      edge1;
      txn_end = 1'b1;
      edge1;
      txn_end = 1'b0;
    end
  endtask

  // ----------------
  // transactions
  // ----------------
  task write_txn(input [7:0] a, input [7:0] d);
    begin
      put_addr(a);
      put_byte(d);
      end_txn;
    end
  endtask
  task read_txn(input [7:0] a);
    begin
      put_addr(a);
      get_byte;
      end_txn;
    end
  endtask
  task unlock(input [7:0] a);
    begin
      write_txn(`OFS_WRITE_KEY, a ^ `UNLOCK_KEY);
    end
  endtask
endmodule

/* sim/pmic_protected_register_bank_bench.sv */
/*
  self-checking bench for the protected register bank.
  assumes: host_ctrl_model drives the byte port, checker bound to the bank.
*/
`timescale 1ns/1ps
`include "pmic_regs_consts.vh"

module pmic_protected_register_bank_bench;
  localparam [7:0] IDENT = 8'h5a; // arbitrary identity value
  localparam [447:0] DFLT = {16'h005a, 16'h013d, 16'h0285, 16'h0300, 16'h04b1, 16'h0580,
    16'h06b2, 16'h07b1, 16'h0800, 16'h0900, 16'h0a05, 16'h0b00, 16'h0c3c, 16'h0d0c, 16'h0e00,
    16'h0f00, 16'h1008, 16'h1106, 16'h1209, 16'h1338, 16'h1400, 16'h1500, 16'h1600, 16'h1700,
    16'h1803, 16'h1c40, 16'h1e00, 16'h2000};
  reg ref_clk = 1'b0;
  reg rst_n = 1'b0;
  reg ce = 1'b1;
  reg hw_reset_pin_n = 1'b1;
  reg push_button_input = 1'b1;
  reg fault = 1'b0;
  reg leave_active = 1'b0;
  reg [7:0] int_flags_in = 8'hf5;
  reg [7:0] status_in = 8'h05;
  reg [7:0] power_good_in = 8'h3c;
  wire sub_addr_we, wr_we, rd_req, txn_end, rd_valid_q, key_live_q, stage_valid_q;
  wire [7:0] sub_addr, wr_data, rd_data_q, ptr_q;
  wire [255:0] reg_image_q;
  integer fails = 0;
  integer check_count = 0;
  integer i;
  reg [7:0] a;
  reg [7:0] v;
  reg dbl;

  always #5 ref_clk = ~ref_clk;

  pmic_protected_register_bank #(.HOLD_CYCLES(20), .CHIP_IDENTITY_VAL(IDENT))
    i_pmic_protected_register_bank (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce),
    .sub_addr_we(sub_addr_we), .sub_addr(sub_addr), .wr_we(wr_we), .wr_data(wr_data),
    .rd_req(rd_req), .txn_end(txn_end), .hw_reset_pin_n(hw_reset_pin_n),
    .push_button_input(push_button_input), .fault(fault), .leave_active(leave_active),
    .int_flags_in(int_flags_in), .status_in(status_in), .power_good_in(power_good_in),
    .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q), .reg_image_q(reg_image_q),
    .ptr_q(ptr_q), .key_live_q(key_live_q), .stage_valid_q(stage_valid_q));
  host_ctrl_model i_host_ctrl_model (.ref_clk(ref_clk), .rd_data_q(rd_data_q),
    .rd_valid_q(rd_valid_q), .sub_addr_we(sub_addr_we), .sub_addr(sub_addr), .wr_we(wr_we),
    .wr_data(wr_data), .rd_req(rd_req), .txn_end(txn_end));

  // ----------------
  // helpers
  // ----------------
  task check(input [7:0] seen, input [7:0] exp);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("CHECK FAILED at %0t: got %h, expected %h", $time, seen, exp);
      end
    end
  endtask
  task rd(input [7:0] ofs, input [7:0] exp);
    begin
      i_host_ctrl_model.read_txn(ofs);
      check({7'h00, i_host_ctrl_model.rd_ok}, 8'h01);
      check(i_host_ctrl_model.rd_seen, exp);
    end
  endtask
  task wt(input [7:0] ofs, input [7:0] d);
    begin
      i_host_ctrl_model.write_txn(ofs, d);
    end
  endtask
  // 0 pin, 1 fault, 2 leave active, 3 long press, 4 short press
  task restore(input integer k);
    begin
      i_host_ctrl_model.edge1;
      hw_reset_pin_n = (k != 0);
      fault = (k == 1);
      leave_active = (k == 2);
      push_button_input = (k < 3);
      repeat (k == 3 ? 30 : (k == 4 ? 10 : 1)) @(posedge ref_clk);
      #1;
      hw_reset_pin_n = 1'b1;
      fault = 1'b0;
      leave_active = 1'b0;
      push_button_input = 1'b1;
      repeat (3) @(posedge ref_clk);
    end
  endtask

  // ----------------
  // scenarios
  // ----------------
  task t_power_on;
    begin
      rd(`OFS_POWER_PATH, `RST_POWER_PATH);
      restore(2);
      for (i = 0; i < 28; i = i + 1) begin
        rd(DFLT[i*16+8 +: 8], DFLT[i*16 +: 8]);
      end
      $display("test power_on done");
    end
  endtask
  task t_unprot;
    begin
      wt(`OFS_CHARGER_CTRL_0, 8'ha5);
      rd(`OFS_CHARGER_CTRL_0, 8'ha5);
      ce = 1'b0;
      wt(`OFS_CHARGER_CTRL_0, 8'h3c);
      ce = 1'b1;
      rd(`OFS_CHARGER_CTRL_0, 8'ha5);
      i_host_ctrl_model.put_addr(`OFS_BACKLIGHT_DUTY);
      i_host_ctrl_model.put_byte(8'h11);
      i_host_ctrl_model.put_byte(8'h22);
      i_host_ctrl_model.end_txn;
      i_host_ctrl_model.put_addr(`OFS_BACKLIGHT_DUTY);
      i_host_ctrl_model.get_byte;
      check(i_host_ctrl_model.rd_seen, 8'h11);
      i_host_ctrl_model.get_byte;
      check(i_host_ctrl_model.rd_seen, 8'h22);
      i_host_ctrl_model.end_txn;
      wt(`OFS_INT_FLAGS_MASKS, 8'hb0);
      rd(`OFS_INT_FLAGS_MASKS, 8'hb5);
      wt(`OFS_DEVICE_STATUS, 8'hff);
      rd(`OFS_DEVICE_STATUS, 8'h85);
      wt(`OFS_CHIP_IDENTITY, 8'hff);
      rd(`OFS_CHIP_IDENTITY, IDENT);
      $display("test unprotected done");
    end
  endtask
  task t_prot;
    begin
      for (a = `OFS_POWER_GOOD_DELAY; a < `OFS_LAST_PROTECTED; a = a + 8'h01) begin
        if (a != `OFS_GAP) begin
          dbl = a >= `OFS_BUCK1 && a <= `OFS_LOAD_SW2;
          i_host_ctrl_model.read_txn(a);
          v = i_host_ctrl_model.rd_seen;
          wt(a, ~v);
          rd(a, v);
          i_host_ctrl_model.unlock(a);
          wt(a, ~v);
          repeat (2) i_host_ctrl_model.edge1;
          check(reg_image_q[{a[4:0], 3'b000} +: 8], dbl ? v : ~v);
          check({7'h00, stage_valid_q}, {7'h00, dbl});
          if (dbl) begin
            i_host_ctrl_model.unlock(a);
            wt(a, ~v);
          end
          rd(a, ~v);
        end
      end
      i_host_ctrl_model.unlock(`OFS_BUCK3);
      rd(`OFS_WRITE_KEY, `OFS_BUCK3 ^ `UNLOCK_KEY);
      rd(`OFS_WRITE_KEY, 8'h00);
      $display("test protected done");
    end
  endtask
  task t_abort;
    begin
      i_host_ctrl_model.unlock(`OFS_BUCK_SLEW);
      wt(`OFS_BUCK_SLEW, 8'h5a);
      rd(`OFS_CHARGER_CTRL_0, 8'ha5);
      i_host_ctrl_model.unlock(`OFS_BUCK_SLEW);
      wt(`OFS_BUCK_SLEW, 8'h5a);
      rd(`OFS_BUCK_SLEW, ~`RST_BUCK_SLEW);
      i_host_ctrl_model.unlock(`OFS_LIN_REG1);
      wt(`OFS_LIN_REG1, 8'h5a);
      i_host_ctrl_model.unlock(`OFS_LIN_REG1);
      wt(`OFS_LIN_REG1, 8'ha5);
      rd(`OFS_LIN_REG1, ~`RST_LIN_REG1);
      i_host_ctrl_model.unlock(`OFS_UNDERVOLTAGE);
      wt(`OFS_RAIL_ENABLES, 8'h99);
      rd(`OFS_RAIL_ENABLES, 8'hff);
      i_host_ctrl_model.unlock(`OFS_POWER_GOOD_DELAY);
      rd(`OFS_CHARGER_CTRL_0, 8'ha5);
      wt(`OFS_POWER_GOOD_DELAY, 8'h77);
      rd(`OFS_POWER_GOOD_DELAY, ~`RST_POWER_GOOD_DELAY);
      $display("test abort done");
    end
  endtask
  task t_restore;
    begin
      for (i = 0; i < 5; i = i + 1) begin
        wt(`OFS_POWER_PATH, 8'h00);
        i_host_ctrl_model.unlock(`OFS_RAIL_ENABLES);
        restore(i);
        wt(`OFS_RAIL_ENABLES, 8'hc3);
        rd(`OFS_POWER_PATH, i == 4 ? 8'h00 : `RST_POWER_PATH);
        rd(`OFS_RAIL_ENABLES, i == 4 ? 8'hc3 : 8'h00);
      end
      $display("test restore done");
    end
  endtask

  task final_report;
    begin
      $display("checks %0d, mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask

  initial begin
    #500000;
    fails = fails + 1;
    final_report;
  end

  initial begin
    repeat (8) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    repeat (3) @(posedge ref_clk);
    t_power_on;
    t_unprot;
    t_prot;
    t_abort;
    t_restore;
    final_report;
  end
endmodule
